//--- common/asp_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants for the application select and power control block
// -----------------------------------------------------------------------------
package asp_pkg;

	// Register offsets on the serial register bus
	localparam logic [7:0] OFS_RUN_APP   = 8'h00; // Running application
	localparam logic [7:0] OFS_APP_REV   = 8'h01; // Application major revision
	localparam logic [7:0] OFS_APP_REQ   = 8'h02; // Application request
	localparam logic [7:0] OFS_CTRL      = 8'he0; // Power and reset control

	// Application codes
	localparam logic [7:0] APP_MEAS      = 8'hc0; // Measurement application
	localparam logic [7:0] APP_BOOT      = 8'h80; // Bootloader

	// Field positions in the power and reset control register
	localparam int         BIT_CPU_RST   = 7;     // Self-clearing processor reset
	localparam int         BIT_CPU_RDY   = 6;     // Firmware-set ready flag
	localparam int         BIT_OSC_ON    = 0;     // Oscillator on request

	// Values after reset
	localparam logic [7:0] RST_RUN_APP   = 8'h00;
	localparam logic [7:0] RST_APP_REV   = 8'h00;
	localparam logic [7:0] RST_APP_REQ   = 8'h00;
	localparam logic       RST_OSC_ON    = 1'b0;  // Device comes up in standby
	localparam logic       RST_CPU_RDY   = 1'b0;

	// Serial bus target address; value is arbitrary
	localparam logic [6:0] BUS_DEV_ADDR  = 7'h2a;
	// Bits in one serial byte
	localparam logic [3:0] BYTE_BITS     = 4'h8;
	// Number of pins passed through the synchroniser
	localparam int         SYNC_W        = 2;

	// Serial target protocol states
	typedef enum logic [2:0] {
		BUS_IDLE     = 3'b000,
		BUS_ADDR     = 3'b001,
		BUS_ACK_ADDR = 3'b010,
		BUS_WRITE    = 3'b011,
		BUS_ACK_WR   = 3'b100,
		BUS_READ     = 3'b101,
		BUS_ACK_RD   = 3'b110
	} asp_bus_state_type;

endpackage

//--- logic/asp_sync.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Two-stage synchroniser for the serial bus pins
// -----------------------------------------------------------------------------
module asp_sync (
	input  wire logic                        mclk,
	input  wire logic                        arst_n,
	input  wire logic [asp_pkg::SYNC_W-1:0]  pin_in,
	output logic      [asp_pkg::SYNC_W-1:0]  pin_sync
);

	// One pair of flops per pin; the first flop feeds only the second
	genvar i;
	generate
		for (i = 0; i < asp_pkg::SYNC_W; i++) begin : g_bit
			logic meta_q; // First stage, may go metastable
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					meta_q      <= 1'b1; // Idle bus level is high
					pin_sync[i] <= 1'b1;
				end else begin
					meta_q      <= pin_in[i];
					pin_sync[i] <= meta_q;
				end
			end
		end
	endgenerate

endmodule

//--- logic/asp_bus_target.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Serial two-wire bus target: pointer byte, then data bytes, auto increment
// -----------------------------------------------------------------------------
module asp_bus_target (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	output logic [7:0]       reg_addr,
	output logic             wr_stb,
	output logic [7:0]       wr_data,
	input  wire logic [7:0]  rd_data
);

	logic [1:0]                    pins_s;   // Synchronised {scl, sda}
	logic                          scl_p_q;  // Previous scl
	logic                          sda_p_q;  // Previous sda
	asp_pkg::asp_bus_state_type    state_q;  // Protocol state
	logic [3:0]                    cnt_q;    // Bits seen in this byte
	logic [7:0]                    shr_q;    // Receive shift register
	logic [7:0]                    tx_q;     // Transmit shift register
	logic                          drv_q;    // Pull sda low
	logic                          rw_q;     // Transfer is a read
	logic                          first_q;  // Next written byte is the pointer
	logic                          nack_q;   // Host declined further data

	asp_sync u_sync (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.pin_in   ({scl_i, sda_i}),
		.pin_sync (pins_s)
	);

	// Bus conditions from the synchronised pins
	wire scl_s  = pins_s[1];
	wire sda_s  = pins_s[0];
	wire start  = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop   = scl_s & scl_p_q & ~sda_p_q & sda_s;
	wire rise   = scl_s & ~scl_p_q;
	wire fall   = ~scl_s & scl_p_q;

	// Open drain: the pin is only ever pulled low
	assign sda_o    = 1'b0;
	assign sda_oe_n = ~drv_q;

	// Edge history
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Protocol engine; start and stop override any byte in flight
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= asp_pkg::BUS_IDLE;
			cnt_q    <= 4'h0;
			shr_q    <= 8'h00;
			tx_q     <= 8'h00;
			drv_q    <= 1'b0;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			nack_q   <= 1'b0;
			reg_addr <= 8'h00;
			wr_stb   <= 1'b0;
			wr_data  <= 8'h00;
		end else begin
			wr_stb <= 1'b0;
			if (start) begin
				state_q <= asp_pkg::BUS_ADDR;
				cnt_q   <= 4'h0;
				drv_q   <= 1'b0;
			end else if (stop) begin
				state_q <= asp_pkg::BUS_IDLE;
				drv_q   <= 1'b0;
			end else if (rise) begin
				// Sample on the rising clock
				if (state_q == asp_pkg::BUS_ADDR || state_q == asp_pkg::BUS_WRITE) begin
					shr_q <= {shr_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end else if (state_q == asp_pkg::BUS_ACK_RD) begin
					nack_q <= sda_s;
				end
			end else if (fall) begin
				// Change the driven level on the falling clock
				unique case (state_q)
					asp_pkg::BUS_IDLE: begin
						drv_q <= 1'b0;
					end
					asp_pkg::BUS_ADDR: begin
						if (cnt_q == asp_pkg::BYTE_BITS) begin
							if (shr_q[7:1] == asp_pkg::BUS_DEV_ADDR) begin
								drv_q   <= 1'b1;
								rw_q    <= shr_q[0];
								state_q <= asp_pkg::BUS_ACK_ADDR;
							end else begin
								state_q <= asp_pkg::BUS_IDLE;
							end
						end
					end
					asp_pkg::BUS_ACK_ADDR: begin
						cnt_q <= 4'h0;
						if (rw_q) begin
							tx_q     <= rd_data;
							drv_q    <= ~rd_data[7];
							reg_addr <= reg_addr + 8'h01;
							state_q  <= asp_pkg::BUS_READ;
						end else begin
							drv_q    <= 1'b0;
							first_q  <= 1'b1;
							state_q  <= asp_pkg::BUS_WRITE;
						end
					end
					asp_pkg::BUS_WRITE: begin
						if (cnt_q == asp_pkg::BYTE_BITS) begin
							drv_q   <= 1'b1;
							state_q <= asp_pkg::BUS_ACK_WR;
							if (first_q) begin
								reg_addr <= shr_q;
							end else begin
								wr_stb  <= 1'b1;
								wr_data <= shr_q;
							end
						end
					end
					asp_pkg::BUS_ACK_WR: begin
						// Pointer moves only after the strobe has been seen
						if (!first_q) begin
							reg_addr <= reg_addr + 8'h01;
						end
						first_q <= 1'b0;
						drv_q   <= 1'b0;
						cnt_q   <= 4'h0;
						state_q <= asp_pkg::BUS_WRITE;
					end
					asp_pkg::BUS_READ: begin
						cnt_q <= cnt_q + 4'h1;
						if (cnt_q == 4'h7) begin
							drv_q   <= 1'b0;
							state_q <= asp_pkg::BUS_ACK_RD;
						end else begin
							drv_q <= ~tx_q[6];
							tx_q  <= {tx_q[6:0], 1'b0};
						end
					end
					asp_pkg::BUS_ACK_RD: begin
						cnt_q <= 4'h0;
						if (nack_q) begin
							state_q <= asp_pkg::BUS_IDLE;
						end else begin
							tx_q     <= rd_data;
							drv_q    <= ~rd_data[7];
							reg_addr <= reg_addr + 8'h01;
							state_q  <= asp_pkg::BUS_READ;
						end
					end
					default: begin
						state_q <= asp_pkg::BUS_IDLE;
						drv_q   <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

//--- logic/asp_ctrl_top.sv
`timescale 1ns/1ps
// Function
// - Running-app register shows measurement or bootloader code
// - Host application request starts that application
// - Control bit 7 issues global processor reset
// - Processor reset bit clears itself
// - Not ready: only control space is usable
// - Ready flag set only by firmware
// - Oscillator-on write starts oscillator, raises wake interrupt
// - Wake: bootloader resets, measurement application idles
// - Oscillator-off write only raises standby interrupt
// - Firmware powers down, then oscillator stops
module asp_ctrl_top (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n,
	input  wire logic        fw_app_we,
	input  wire logic [7:0]  fw_app_id,
	input  wire logic [7:0]  fw_app_rev,
	input  wire logic        fw_ready_set,
	input  wire logic        fw_osc_off,
	output logic             app_start,
	output logic [7:0]       requested_app_code,
	output logic             cpu_rst,
	output logic             cpu_ready,
	output logic             osc_en,
	output logic             standby,
	output logic             oscillator_wake_interrupt,
	output logic             idle_req,
	output logic             standby_irq
);

	// -------------------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------------------
	logic [7:0] reg_addr;      // Register pointer from the serial target
	logic       wr_stb;        // One-cycle host write strobe
	logic [7:0] wr_data;       // Host write data
	logic [7:0] rd_data;       // Read data for the current pointer
	logic [7:0] run_app_q;     // Running application code
	logic [7:0] app_rev_q;     // Major revision field
	logic [7:0] app_req_q;     // Last requested application
	logic       app_start_q;   // Start pulse to firmware
	logic       cpu_rst_q;     // Self-clearing reset bit
	logic       cpu_rdy_q;     // Firmware ready flag
	logic       osc_q;         // Oscillator running
	logic       stby_pend_q;   // Standby asked, firmware not done yet
	logic       wake_q;        // Wake interrupt pulse
	logic       idle_q;        // Idle request pulse
	logic       stby_irq_q;    // Standby interrupt pulse

	// -------------------------------------------------------------------------
	// Serial bus target
	// -------------------------------------------------------------------------
	asp_bus_target u_bus (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.scl_i    (scl_i),
		.sda_i    (sda_i),
		.sda_o    (sda_o),
		.sda_oe_n (sda_oe_n),
		.reg_addr (reg_addr),
		.wr_stb   (wr_stb),
		.wr_data  (wr_data),
		.rd_data  (rd_data)
	);

	// -------------------------------------------------------------------------
	// Write decode
	// -------------------------------------------------------------------------
	// Application space is closed until firmware says it is ready
	wire app_space_ok = cpu_rdy_q;
	wire wr_ctrl  = wr_stb && (reg_addr == asp_pkg::OFS_CTRL);
	wire wr_run   = wr_stb && app_space_ok && (reg_addr == asp_pkg::OFS_RUN_APP);
	wire wr_rev   = wr_stb && app_space_ok && (reg_addr == asp_pkg::OFS_APP_REV);
	wire wr_req   = wr_stb && app_space_ok && (reg_addr == asp_pkg::OFS_APP_REQ);
	// Oscillator bit transitions; only the 0 to 1 edge wakes the device
	wire osc_wake = wr_ctrl && wr_data[asp_pkg::BIT_OSC_ON] && !osc_q;
	wire osc_down = wr_ctrl && !wr_data[asp_pkg::BIT_OSC_ON] && osc_q;
	// Anything that is not the measurement application handles wake by reset
	wire wake_rst = osc_wake && (run_app_q != asp_pkg::APP_MEAS);

	// -------------------------------------------------------------------------
	// Application registers
	// -------------------------------------------------------------------------
	// Running application and revision; firmware update beats a host write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			run_app_q <= asp_pkg::RST_RUN_APP;
			app_rev_q <= asp_pkg::RST_APP_REV;
		end else if (cpu_rst_q) begin
			// Processor registers return to reset values
			run_app_q <= asp_pkg::RST_RUN_APP;
			app_rev_q <= asp_pkg::RST_APP_REV;
		end else if (fw_app_we) begin
			run_app_q <= fw_app_id;
			app_rev_q <= fw_app_rev;
		end else begin
			if (wr_run) begin
				run_app_q <= wr_data;
			end
			if (wr_rev) begin
				app_rev_q <= wr_data;
			end
		end
	end

	// Application request and its start pulse to firmware
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			app_req_q   <= asp_pkg::RST_APP_REQ;
			app_start_q <= 1'b0;
		end else begin
			app_start_q <= wr_req;
			if (wr_req) begin
				app_req_q <= wr_data;
			end else if (cpu_rst_q) begin
				app_req_q <= asp_pkg::RST_APP_REQ;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Processor reset and ready
	// -------------------------------------------------------------------------
	// Reset bit is a one-cycle pulse so the host never writes it back to zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_rst_q <= 1'b0;
		end else begin
			cpu_rst_q <= (wr_ctrl && wr_data[asp_pkg::BIT_CPU_RST]) || wake_rst;
		end
	end

	// Ready only ever rises from firmware; set wins over a coincident reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_rdy_q <= asp_pkg::RST_CPU_RDY;
		end else if (fw_ready_set) begin
			cpu_rdy_q <= 1'b1;
		end else if (cpu_rst_q) begin
			cpu_rdy_q <= 1'b0;
		end
	end

	// -------------------------------------------------------------------------
	// Oscillator and standby
	// -------------------------------------------------------------------------
	// Hardware starts the oscillator; stopping it waits for firmware, since
	// cutting the clock under live modules could leave them in a bad state
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			osc_q       <= asp_pkg::RST_OSC_ON;
			stby_pend_q <= 1'b0;
		end else if (osc_wake) begin
			osc_q       <= 1'b1;
			stby_pend_q <= 1'b0;
		end else if (osc_down) begin
			stby_pend_q <= 1'b1;
		end else if (stby_pend_q && fw_osc_off) begin
			osc_q       <= 1'b0;
			stby_pend_q <= 1'b0;
		end
	end

	// Interrupt pulses towards the processor
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wake_q     <= 1'b0;
			idle_q     <= 1'b0;
			stby_irq_q <= 1'b0;
		end else begin
			wake_q     <= osc_wake;
			idle_q     <= osc_wake && !wake_rst;
			stby_irq_q <= osc_down;
		end
	end

	// -------------------------------------------------------------------------
	// Read mux
	// -------------------------------------------------------------------------
	// Unmapped offsets and a closed application space read as zero
	always_comb begin
		rd_data = 8'h00;
		unique case (reg_addr)
			asp_pkg::OFS_RUN_APP: rd_data = app_space_ok ? run_app_q : 8'h00;
			asp_pkg::OFS_APP_REV: rd_data = app_space_ok ? app_rev_q : 8'h00;
			asp_pkg::OFS_APP_REQ: rd_data = app_space_ok ? app_req_q : 8'h00;
			asp_pkg::OFS_CTRL:    rd_data = {cpu_rst_q, cpu_rdy_q, 5'h00, osc_q};
			default:              rd_data = 8'h00;
		endcase
	end

	// Outputs
	assign app_start                 = app_start_q;
	assign requested_app_code        = app_req_q;
	assign cpu_rst                   = cpu_rst_q;
	assign cpu_ready                 = cpu_rdy_q;
	assign osc_en                    = osc_q;
	assign standby                   = ~osc_q;
	assign oscillator_wake_interrupt = wake_q;
	assign idle_req                  = idle_q;
	assign standby_irq               = stby_irq_q;

	// -------------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------------
	// Host write of one byte to the control register
	sequence s_ctrl_wr;
		wr_stb && (reg_addr == asp_pkg::OFS_CTRL);
	endsequence

	// Request write is followed by a start pulse carrying the code
	property p_app_req;
		@(posedge mclk) disable iff (!arst_n)
		wr_req |=> app_start && (requested_app_code == $past(wr_data));
	endproperty
	a_app_req: assert property (p_app_req) else $error("request did not start app");

	// Reset bit rises on the write and is gone one cycle later
	property p_rst_pulse;
		@(posedge mclk) disable iff (!arst_n)
		s_ctrl_wr ##0 wr_data[asp_pkg::BIT_CPU_RST] |=> cpu_rst ##1 !cpu_rst || $past(wake_rst);
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset bit not self clearing");

	// Global reset wipes ready and the running application code
	property p_rst_clears;
		@(posedge mclk) disable iff (!arst_n)
		cpu_rst && !fw_ready_set && !fw_app_we |=> !cpu_ready && (run_app_q == asp_pkg::RST_RUN_APP);
	endproperty
	a_rst_clears: assert property (p_rst_clears) else $error("reset left state behind");

	// Ready rises only after a firmware set
	property p_ready_fw;
		@(posedge mclk) disable iff (!arst_n)
		$rose(cpu_ready) |-> $past(fw_ready_set);
	endproperty
	a_ready_fw: assert property (p_ready_fw) else $error("ready rose without firmware");

	// Oscillator wake sequence
	sequence s_wake_wr;
		s_ctrl_wr ##0 wr_data[asp_pkg::BIT_OSC_ON] && !osc_en;
	endsequence
	property p_wake;
		@(posedge mclk) disable iff (!arst_n)
		s_wake_wr |=> osc_en && oscillator_wake_interrupt ##1 !oscillator_wake_interrupt;
	endproperty
	a_wake: assert property (p_wake) else $error("oscillator wake missing");

	// Wake goes to reset for the bootloader, to idle for the application;
	// a host reset bit in the same write may still pulse reset alongside idle
	property p_wake_route;
		@(posedge mclk) disable iff (!arst_n)
		oscillator_wake_interrupt |-> (idle_req == ($past(run_app_q) == asp_pkg::APP_MEAS)) &&
			(idle_req != $past(wake_rst)) && (!$past(wake_rst) || cpu_rst);
	endproperty
	a_wake_route: assert property (p_wake_route) else $error("wake routed wrongly");

	// Writing zero keeps the oscillator running and asks for standby
	property p_down;
		@(posedge mclk) disable iff (!arst_n)
		s_ctrl_wr ##0 !wr_data[asp_pkg::BIT_OSC_ON] && osc_en |=> osc_en && standby_irq ##1 osc_en;
	endproperty
	a_down: assert property (p_down) else $error("oscillator stopped directly");

	// Oscillator stops only on firmware completion of a pending standby
	property p_stop_order;
		@(posedge mclk) disable iff (!arst_n)
		$fell(osc_en) |-> $past(stby_pend_q) && $past(fw_osc_off) && standby;
	endproperty
	a_stop_order: assert property (p_stop_order) else $error("oscillator stopped too early");

	// Application space stays closed while not ready
	property p_closed;
		@(posedge mclk) disable iff (!arst_n)
		!cpu_ready && wr_stb && (reg_addr < asp_pkg::OFS_CTRL) && !fw_app_we && !cpu_rst
			|=> $stable(run_app_q) && $stable(app_rev_q) && !app_start;
	endproperty
	a_closed: assert property (p_closed) else $error("write accepted while not ready");

	// Running-application read returns the stored code
	property p_run_read;
		@(posedge mclk) disable iff (!arst_n)
		cpu_ready && (reg_addr == asp_pkg::OFS_RUN_APP) |-> rd_data == run_app_q;
	endproperty
	a_run_read: assert property (p_run_read) else $error("running app read wrong");

	// Unassigned control bits always read zero
	property p_ctrl_zero;
		@(posedge mclk) disable iff (!arst_n)
		(reg_addr == asp_pkg::OFS_CTRL) |-> (rd_data[5:1] == 5'h00);
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused control bits set");

endmodule

//--- test/asp_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host model: two-wire bus master with an open-drain data pin
// ---------------------------------------------------------------
module asp_host_model (
	input  wire logic mclk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_dn
);
	int   n_nak; // Missing acknowledges
	logic b;     // Scratch bit
	initial begin
		scl = 1'b1;
		sda_dn = 1'b0;
		n_nak = 0;
	end
	// Wait n edges, then step just past the last one
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Data moves mid-low so it never races the clock pin
	task automatic bo(input logic v);
		sda_dn = ~v;
		wt(4);
		scl = 1'b1;
		wt(8);
		scl = 1'b0;
		wt(4);
	endtask
	// Release data, sample late in the high phase
	task automatic bi(output logic v);
		sda_dn = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(6);
		v = sda_w;
		wt(2);
		scl = 1'b0;
		wt(4);
	endtask
	// Start, also usable as repeated start
	task automatic st();
		sda_dn = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_dn = 1'b1;
		wt(8);
		scl = 1'b0;
		wt(4);
	endtask
	task automatic sp();
		sda_dn = 1'b1;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_dn = 1'b0;
		wt(8);
	endtask
	// One byte out, MSB first, then the device acknowledge
	task automatic tx(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) bo(d[i]);
		bi(b);
		if (b !== 1'b0) n_nak++;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		st();
		tx({asp_pkg::BUS_DEV_ADDR, 1'b0});
		tx(a);
		tx(d);
		sp();
	endtask
	// Pointer write, repeated start, one byte read, then NACK
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		st();
		tx({asp_pkg::BUS_DEV_ADDR, 1'b0});
		tx(a);
		st();
		tx({asp_pkg::BUS_DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) bi(d[i]);
		bo(1'b1);
		sp();
	endtask
	// Poll the running-app register until it shows the request
	task automatic poll(input logic [7:0] want, output logic [7:0] got);
		for (int i = 0; i < 16; i++) begin
			rd(asp_pkg::OFS_RUN_APP, got);
			if (got === want) break;
		end
	endtask
endmodule

//--- test/testbench.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Self-checking bench for the control register block
// ---------------------------------------------------------------
module testbench;
	logic       mclk, arst_n, scl, sda_dn, sda_w, sda_o, sda_oe_n;
	logic       fw_app_we, fw_ready_set, fw_osc_off, app_start, cpu_rst;
	logic       cpu_ready, osc_en, standby, wake, idle_req, standby_irq;
	logic [7:0] fw_app_id, fw_app_rev, req_code, rd, rev, rcode;
	int         num_errors, n_checks, cyc, n_st, n_rst, n_wk, n_idl, n_sb;
	// Open-drain data wire with pull-up
	assign sda_w = (sda_dn || sda_oe_n === 1'b0) ? 1'b0 : 1'b1;
	asp_ctrl_top u_dut (.mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .fw_app_we(fw_app_we), .fw_app_id(fw_app_id),
		.fw_app_rev(fw_app_rev), .fw_ready_set(fw_ready_set), .fw_osc_off(fw_osc_off),
		.app_start(app_start), .requested_app_code(req_code), .cpu_rst(cpu_rst),
		.cpu_ready(cpu_ready), .osc_en(osc_en), .standby(standby),
		.oscillator_wake_interrupt(wake), .idle_req(idle_req), .standby_irq(standby_irq));
	asp_host_model u_host (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_dn(sda_dn));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Pulse counters; the ceiling cuts a hung bus short
	always @(posedge mclk) begin
		cyc++;
		n_st += int'(app_start === 1'b1);
		n_rst += int'(cpu_rst === 1'b1);
		n_wk += int'(wake === 1'b1);
		n_idl += int'(idle_req === 1'b1);
		n_sb += int'(standby_irq === 1'b1);
		if (cyc == 90000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Firmware strobes last one cycle
	task automatic fw(input logic we, input logic rs, input logic off);
		@(posedge mclk);
		#1;
		fw_app_we = we;
		fw_ready_set = rs;
		fw_osc_off = off;
		@(posedge mclk);
		#1;
		fw_app_we = 1'b0;
		fw_ready_set = 1'b0;
		fw_osc_off = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hb1a1124a));
		{arst_n, fw_app_we, fw_ready_set, fw_osc_off} = 4'h0;
		fw_app_id = 8'h00;
		fw_app_rev = 8'h00;
		repeat (8) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		// Not ready: application space closed, control reads zero
		u_host.rd(asp_pkg::OFS_CTRL, rd);
		chk(rd, 8'h00);
		u_host.wr(asp_pkg::OFS_APP_REQ, asp_pkg::APP_MEAS);
		chk(8'(n_st), 8'h00);
		fw(1'b0, 1'b1, 1'b0);
		u_host.rd(asp_pkg::OFS_APP_REQ, rd);
		chk(rd, 8'h00);
		u_host.rd(asp_pkg::OFS_CTRL, rd);
		chk(rd, 8'h40);
		// Wake with no app loaded counts as bootloader: hardware reset
		u_host.wr(asp_pkg::OFS_CTRL, 8'h3f);
		chk(8'(n_wk), 8'h01);
		chk(8'(n_rst), 8'h01);
		chk(8'(n_idl), 8'h00);
		u_host.rd(asp_pkg::OFS_CTRL, rd);
		chk(rd, 8'h01);
		rev = 8'($urandom);
		fw_app_rev = rev;
		fw_app_id = asp_pkg::APP_MEAS;
		fw(1'b1, 1'b1, 1'b0);
		u_host.rd(asp_pkg::OFS_RUN_APP, rd);
		chk(rd, asp_pkg::APP_MEAS);
		u_host.rd(asp_pkg::OFS_APP_REV, rd);
		chk(rd, rev);
		// Host write of the revision register once the space is open
		rev = 8'($urandom);
		u_host.wr(asp_pkg::OFS_APP_REV, rev);
		u_host.rd(asp_pkg::OFS_APP_REV, rd);
		chk(rd, rev);
		// Random switches; firmware follows, host polls for it
		for (int i = 0; i < 4; i++) begin
			rcode = ($urandom % 2) ? asp_pkg::APP_MEAS : asp_pkg::APP_BOOT;
			u_host.wr(asp_pkg::OFS_APP_REQ, rcode);
			chk(8'(n_st), 8'(i + 1));
			chk(req_code, rcode);
			fw_app_id = rcode;
			fw(1'b1, 1'b0, 1'b0);
			u_host.poll(rcode, rd);
			chk(rd, rcode);
		end
		fw_app_id = asp_pkg::APP_MEAS;
		fw(1'b1, 1'b0, 1'b0);
		// Standby: oscillator holds until firmware powers down
		u_host.wr(asp_pkg::OFS_CTRL, 8'h00);
		chk(8'(n_sb), 8'h01);
		chk({7'h00, osc_en}, 8'h01);
		fw(1'b0, 1'b0, 1'b1);
		chk({7'h00, standby}, 8'h01);
		// Wake under measurement app: idle request, no reset
		u_host.wr(asp_pkg::OFS_CTRL, 8'h01);
		chk(8'(n_idl), 8'h01);
		chk(8'(n_rst), 8'h01);
		u_host.rd(asp_pkg::OFS_CTRL, rd);
		chk(rd, 8'h41);
		// Processor reset clears itself and the app registers
		u_host.wr(asp_pkg::OFS_CTRL, 8'h81);
		chk(8'(n_rst), 8'h02);
		u_host.rd(asp_pkg::OFS_CTRL, rd);
		chk(rd, 8'h01);
		fw(1'b0, 1'b1, 1'b0);
		u_host.rd(asp_pkg::OFS_RUN_APP, rd);
		chk(rd, 8'h00);
		u_host.rd(8'h10, rd);
		chk(rd, 8'h00);
		chk({7'h00, cpu_ready}, 8'h01);
		chk({7'h00, sda_o}, 8'h00);
		chk(8'(u_host.n_nak), 8'h00);
		results();
	end
endmodule
